/* File: rtl/aofc_pkg.sv */
// Constants for the ADC output format and configuration bank.
// Assumes one sample clock domain; serial control pins arrive unsynchronised.
package aofc_pkg;

  // Serial control frame: 8 address bits then 16 data bits
  localparam int unsigned AOFC_ADDR_W   = 8;
  localparam int unsigned AOFC_DATA_W   = 16;
  localparam int unsigned AOFC_SHIFT_W  = 23;         // Bits held before the last one lands
  localparam logic [4:0]  AOFC_FRAME_LAST = 5'h17;    // Index of the 24th serial bit

  // Register addresses
  localparam logic [7:0] AOFC_ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] AOFC_ADDR_NOISE_SUPP = 8'h14;
  localparam logic [7:0] AOFC_ADDR_POLARITY   = 8'h24;
  localparam logic [7:0] AOFC_ADDR_GAIN_A     = 8'h2A;
  localparam logic [7:0] AOFC_ADDR_GAIN_B     = 8'h2B;
  localparam logic [7:0] AOFC_ADDR_CLK_REF    = 8'h42;  // clock_reference_phase_config
  localparam logic [7:0] AOFC_ADDR_TEST_PAT   = 8'h45;  // test_pattern_select
  localparam logic [7:0] AOFC_ADDR_OUT_FMT    = 8'h46;  // output_format_config

  // Field positions
  localparam int unsigned AOFC_BIT_SOFT_RESET = 0;
  localparam int unsigned AOFC_BIT_TWO_WIRE   = 0;
  localparam int unsigned AOFC_BIT_DUTY       = 2;
  localparam int unsigned AOFC_BIT_CM_REF     = 3;
  localparam int unsigned AOFC_BIT_PHASE_LO   = 5;      // Two-bit field D6..D5
  localparam int unsigned AOFC_BIT_SKEW_PAT   = 0;
  localparam int unsigned AOFC_BIT_ALIGN_PAT  = 1;
  localparam int unsigned AOFC_BIT_TWOS       = 2;
  localparam int unsigned AOFC_BIT_MSB_FIRST  = 3;
  localparam int unsigned AOFC_BIT_SINGLE     = 4;
  localparam int unsigned AOFC_BIT_CENTER     = 13;

  // Channels and sample coding
  localparam int unsigned AOFC_CH        = 8;
  localparam int unsigned AOFC_RES       = 12;
  localparam logic [11:0] AOFC_SIGN_FLIP = 12'h800;
  localparam logic [11:0] AOFC_POS_SAT   = 12'h7FF;
  localparam logic [11:0] AOFC_NEG_SAT   = 12'h800;
  localparam logic [11:0] AOFC_SKEW_PAT  = 12'h555;   // Alternating ones and zeros
  localparam logic [11:0] AOFC_ALIGN_PAT = 12'hFC0;   // Six ones then six zeros

  // Digital gain, 1 dB steps, factors in Q8 (code 0 is unity)
  localparam logic [3:0]  AOFC_GAIN_MAX  = 4'hC;
  localparam int unsigned AOFC_GAIN_FRAC = 8;
  localparam logic [12:0][10:0] AOFC_GAIN_Q8 = {
    11'h3FC, 11'h38E, 11'h32B, 11'h2D3, 11'h284, 11'h23E, 11'h1FF,
    11'h1C8, 11'h196, 11'h16A, 11'h142, 11'h11F, 11'h100};

  // Serializer timing: every bit lasts four clock ticks
  localparam logic [1:0] AOFC_TICK_LAST = 2'h3;
  localparam logic [3:0] AOFC_BIT_LAST  = 4'hB;
  localparam logic [3:0] AOFC_BIT_HALF  = 4'h6;       // Frame marker high for first half

endpackage

/* File: rtl/aofc_core.sv */
// Configuration bank and serial output path of an octal ADC: serial control
// port, sample formatting per channel, and the bit-serial data/clock outputs.
// Assumes samples come from logic on mclk_in; control pins are asynchronous.
//
// What this block does, and what its controller must write
// [R01] Register 42 D0 selects differential clock, default single
// [R02] Register 42 D2 turns on duty correction
// [R03] Register 42 D3 moves reference drive to common-mode
// [R04] Register 42 D6..D5 set bit-clock phase, default 90
// [R05] Register 45 D0 sends skew training pattern
// [R06] Register 45 D1 sends frame align pattern
// [R07] Register 46 D2 selects two's complement output
// [R08] Register 46 D3 sends most significant bit first
// [R09] Register 46 D4 selects single rate, 12x clock
// [R10] Register 46 D13 picks centre edge in single rate
// [R11] Noise suppression toggles zero output at half rate
// [R12] Registers 2A/2B set 0 to 12 dB gain
// [R13] Register 24 inverts channel polarity
// [R14] Controller writes forced ones and zeros as marked
// [R15] Controller writes zero to unused bit positions
// [R16] Controller writes all register fields in one write
`timescale 1ns/1ps

module aofc_core (
  input  wire logic             mclk_in,                              // Sample-rate system clock
  input  wire logic             arst_n_in,                            // Asynchronous reset, active low
  input  wire logic             ce_in,                                // Clock enable, freezes all state
  input  wire logic             sen_n_in,                             // Serial control select, active low
  input  wire logic             sclk_in,                              // Serial control clock
  input  wire logic             sdata_in,                             // Serial control data
  input  wire logic [7:0][11:0] adc_code_in,                          // Raw conversion codes, offset binary
  input  wire logic             sample_valid_in,                      // One-cycle strobe per new sample set
  output logic      [7:0]       serial_data_out,                      // One serial lane per channel
  output logic                  serial_bit_clock_out,                 // Bit clock beside the data
  output logic                  frame_clock_out,                      // High for first half of each word
  output logic                  two_wire_clock_input_select_out,      // Differential sample clock chosen
  output logic                  duty_correction_on_out,               // Duty-cycle correction enabled
  output logic                  reference_via_common_mode_pin_out     // Reference driven via common-mode pin
);

  // Serial control port states, Gray along idle -> shift -> done
  typedef enum logic [1:0] {
    AOFC_SP_IDLE  = 2'b00,
    AOFC_SP_SHIFT = 2'b01,
    AOFC_SP_DONE  = 2'b11
  } aofc_sp_e;

  // Everything software can program; all fields reset to zero
  typedef struct packed {
    logic        two_wire_clock_input_select;
    logic        duty_correction_on;
    logic        reference_via_common_mode_pin;
    logic [1:0]  clock_phase_code;
    logic        skew_training_pattern_on;
    logic        frame_align_pattern_on;
    logic        twos_complement_output;
    logic        msb_first_select;
    logic        single_rate_serial_select;
    logic        single_rate_center_edge_select;
    logic [7:0]  noise_suppress_on;
    logic [7:0]  polarity_swap_on;
    logic [15:0] gain_a;
    logic [15:0] gain_b;
  } aofc_cfg_s;

  // Whole module state
  typedef struct packed {
    logic             sel_meta;     // Synchroniser first stages
    logic             sclk_meta;
    logic             sdata_meta;
    logic             sel_sync;     // Synchroniser second stages
    logic             sclk_sync;
    logic             sdata_sync;
    logic             sclk_prev;    // Edge history of the synchronised clock
    aofc_sp_e         sp_state;
    logic [4:0]       bit_cnt;
    logic [22:0]      shreg;
    aofc_cfg_s        cfg;
    logic [7:0][11:0] hold;         // Latest formatted sample per channel
    logic             noise_phase;  // Flips every sample, half-rate toggle
    logic [7:0][11:0] word;         // Word being shifted out
    logic [3:0]       bit_idx;
    logic [1:0]       tick;
    logic [7:0]       ser_out;
    logic             bit_clk;
    logic             frame;
  } aofc_state_s;

  aofc_state_s      s;              // Registered state
  aofc_state_s      next_s;         // Next value
  logic [7:0][11:0] proc_word;      // Formatted sample of each channel

  // Per-channel sample path: polarity, gain, noise toggle, format
  genvar ch;
  generate
    for (ch = 0; ch < aofc_pkg::AOFC_CH; ch++)
    begin : g_chan
      logic [3:0]         raw_gain;
      logic [3:0]         gain_code;
      logic signed [11:0] centred;
      logic signed [11:0] swapped;
      logic signed [12:0] factor;
      logic signed [24:0] product;
      logic signed [24:0] scaled;
      logic [11:0]        gained;
      logic [11:0]        toggled;

      // Gain nibbles run upward in 2A and downward in 2B
      if (ch < 4)
      begin : g_lo
        assign raw_gain = s.cfg.gain_a[4*ch +: 4];
      end
      else
      begin : g_hi
        assign raw_gain = s.cfg.gain_b[4*(7-ch) +: 4];
      end

      always_comb
      begin
        // Codes above 12 dB clamp rather than wrap
        gain_code = (raw_gain > aofc_pkg::AOFC_GAIN_MAX) ? aofc_pkg::AOFC_GAIN_MAX : raw_gain;  // [R12]
        centred   = signed'(adc_code_in[ch] ^ aofc_pkg::AOFC_SIGN_FLIP);
        // One's complement keeps full scale in range, at the cost of one LSB
        swapped   = s.cfg.polarity_swap_on[ch] ? ~centred : centred;  // [R13]
        factor    = signed'({2'b00, aofc_pkg::AOFC_GAIN_Q8[gain_code]});
        product   = swapped * factor;  // [R12]
        scaled    = product >>> aofc_pkg::AOFC_GAIN_FRAC;
        // Saturate instead of wrapping on overflow
        if (scaled[24:11] == {14{scaled[24]}})
        begin
          gained = scaled[11:0];
        end
        else
        begin
          gained = scaled[24] ? aofc_pkg::AOFC_NEG_SAT : aofc_pkg::AOFC_POS_SAT;
        end
        // Zero input then alternates every sample, i.e. at half the sample rate
        toggled = gained ^ {11'h000, s.cfg.noise_suppress_on[ch] & s.noise_phase};  // [R11]
        // Offset binary flips the sign bit back
        proc_word[ch] = s.cfg.twos_complement_output ? toggled
                                                     : (toggled ^ aofc_pkg::AOFC_SIGN_FLIP);  // [R07]
      end
    end
  endgenerate

  // Next-state logic for control port, registers and serializer
  always_comb
  begin
    logic        sclk_rise;
    logic [23:0] frame_bits;
    logic [3:0]  bit_sel;
    logic [2:0]  phase_off;
    logic [2:0]  pair_pos;
    sclk_rise  = 1'b0;
    frame_bits = '0;
    bit_sel    = '0;
    phase_off  = '0;
    pair_pos   = '0;
    next_s     = s;
    if (ce_in)
    begin
      // Two-flop synchronisers on all control pins
      next_s.sel_meta   = ~sen_n_in;
      next_s.sclk_meta  = sclk_in;
      next_s.sdata_meta = sdata_in;
      next_s.sel_sync   = s.sel_meta;
      next_s.sclk_sync  = s.sclk_meta;
      next_s.sdata_sync = s.sdata_meta;
      next_s.sclk_prev  = s.sclk_sync;
      sclk_rise         = s.sclk_sync & ~s.sclk_prev;

      // Serial write: address then data, MSB first, latched on rising clock
      unique case (s.sp_state)
        AOFC_SP_IDLE:
        begin
          // Start of a frame
          if (s.sel_sync)
          begin
            next_s.sp_state = AOFC_SP_SHIFT;
            next_s.bit_cnt  = '0;
          end
        end
        AOFC_SP_SHIFT:
        begin
          if (!s.sel_sync)
          begin
            // Short frame dropped without writing anything
            next_s.sp_state = AOFC_SP_IDLE;
          end
          else if (sclk_rise)
          begin
            if (s.bit_cnt == aofc_pkg::AOFC_FRAME_LAST)
            begin
              // Whole register is replaced in one go; partial updates do not exist
              frame_bits      = {s.shreg, s.sdata_sync};  // [R16]
              next_s.sp_state = AOFC_SP_DONE;
              // Only named fields are stored; forced and unused bits are dropped
              unique case (frame_bits[23:16])  // [R14] [R15]
                aofc_pkg::AOFC_ADDR_SOFT_RESET:
                begin
                  // Self-clearing: nothing to store, all fields to defaults
                  if (frame_bits[aofc_pkg::AOFC_BIT_SOFT_RESET])
                  begin
                    next_s.cfg = '0;
                  end
                end
                aofc_pkg::AOFC_ADDR_NOISE_SUPP:
                  next_s.cfg.noise_suppress_on = frame_bits[7:0];  // [R11]
                aofc_pkg::AOFC_ADDR_POLARITY:
                  next_s.cfg.polarity_swap_on = frame_bits[7:0];  // [R13]
                aofc_pkg::AOFC_ADDR_GAIN_A:
                  next_s.cfg.gain_a = frame_bits[15:0];  // [R12]
                aofc_pkg::AOFC_ADDR_GAIN_B:
                  next_s.cfg.gain_b = frame_bits[15:0];  // [R12]
                aofc_pkg::AOFC_ADDR_CLK_REF:
                begin
                  next_s.cfg.two_wire_clock_input_select   = frame_bits[aofc_pkg::AOFC_BIT_TWO_WIRE];  // [R01]
                  next_s.cfg.duty_correction_on            = frame_bits[aofc_pkg::AOFC_BIT_DUTY];  // [R02]
                  next_s.cfg.reference_via_common_mode_pin = frame_bits[aofc_pkg::AOFC_BIT_CM_REF];  // [R03]
                  next_s.cfg.clock_phase_code = frame_bits[aofc_pkg::AOFC_BIT_PHASE_LO +: 2];  // [R04]
                end
                aofc_pkg::AOFC_ADDR_TEST_PAT:
                begin
                  next_s.cfg.skew_training_pattern_on = frame_bits[aofc_pkg::AOFC_BIT_SKEW_PAT];  // [R05]
                  next_s.cfg.frame_align_pattern_on   = frame_bits[aofc_pkg::AOFC_BIT_ALIGN_PAT];  // [R06]
                end
                aofc_pkg::AOFC_ADDR_OUT_FMT:
                begin
                  next_s.cfg.twos_complement_output    = frame_bits[aofc_pkg::AOFC_BIT_TWOS];  // [R07]
                  next_s.cfg.msb_first_select          = frame_bits[aofc_pkg::AOFC_BIT_MSB_FIRST];  // [R08]
                  next_s.cfg.single_rate_serial_select = frame_bits[aofc_pkg::AOFC_BIT_SINGLE];  // [R09]
                  next_s.cfg.single_rate_center_edge_select = frame_bits[aofc_pkg::AOFC_BIT_CENTER];  // [R10]
                end
                default:
                begin
                  // Other addresses are accepted and ignored
                end
              endcase
            end
            else
            begin
              next_s.shreg   = {s.shreg[21:0], s.sdata_sync};
              next_s.bit_cnt = s.bit_cnt + 5'h01;
            end
          end
        end
        AOFC_SP_DONE:
        begin
          // Extra clocks after 24 bits are ignored until deselect
          if (!s.sel_sync)
          begin
            next_s.sp_state = AOFC_SP_IDLE;
          end
        end
        default:
        begin
          next_s.sp_state = AOFC_SP_IDLE;
        end
      endcase

      // Capture newest formatted samples; overrun keeps the latest
      if (sample_valid_in)
      begin
        next_s.hold        = proc_word;
        next_s.noise_phase = ~s.noise_phase;  // [R11]
      end

      // Output bit of the current position, order per setting
      bit_sel = s.cfg.msb_first_select ? (aofc_pkg::AOFC_BIT_LAST - s.bit_idx) : s.bit_idx;  // [R08]
      for (int i = 0; i < aofc_pkg::AOFC_CH; i++)
      begin
        next_s.ser_out[i] = s.word[i][bit_sel];
      end

      // Bit clock: one period per bit in single rate, per two bits otherwise
      if (s.cfg.single_rate_serial_select)
      begin
        // Rising edge sits mid-bit unless the falling edge is chosen
        next_s.bit_clk = s.tick[1] ^ s.cfg.single_rate_center_edge_select;  // [R09] [R10]
      end
      else
      begin
        // Each code step shifts the clock a quarter period; code 0 gives 90 degrees
        phase_off      = {2'(s.cfg.clock_phase_code + 2'h1), 1'b0};  // [R04]
        pair_pos       = {s.bit_idx[0], s.tick} - phase_off;
        next_s.bit_clk = pair_pos[2];
      end
      next_s.frame = (s.bit_idx < aofc_pkg::AOFC_BIT_HALF);

      // Advance bit position; reload a word at each word boundary
      if (s.tick == aofc_pkg::AOFC_TICK_LAST)
      begin
        next_s.tick = '0;
        if (s.bit_idx == aofc_pkg::AOFC_BIT_LAST)
        begin
          next_s.bit_idx = '0;
          for (int i = 0; i < aofc_pkg::AOFC_CH; i++)
          begin
            // Skew pattern wins should both test modes be set
            if (s.cfg.skew_training_pattern_on)
            begin
              next_s.word[i] = aofc_pkg::AOFC_SKEW_PAT;  // [R05]
            end
            else if (s.cfg.frame_align_pattern_on)
            begin
              next_s.word[i] = aofc_pkg::AOFC_ALIGN_PAT;  // [R06]
            end
            else
            begin
              next_s.word[i] = s.hold[i];
            end
          end
        end
        else
        begin
          next_s.bit_idx = s.bit_idx + 4'h1;
        end
      end
      else
      begin
        next_s.tick = s.tick + 2'h1;
      end
    end
  end

  // State register; every field resets to zero
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign serial_data_out                   = s.ser_out;
  assign serial_bit_clock_out              = s.bit_clk;
  assign frame_clock_out                   = s.frame;
  assign two_wire_clock_input_select_out   = s.cfg.two_wire_clock_input_select;  // [R01]
  assign duty_correction_on_out            = s.cfg.duty_correction_on;  // [R02]
  assign reference_via_common_mode_pin_out = s.cfg.reference_via_common_mode_pin;  // [R03]

endmodule // aofc_core

/* File: dv/aofc_core_props.sv */
// Checker for the output bank: config pins and serial output timing.
// Assumes it is bound to aofc_core and sees only that module's ports.
`timescale 1ns/1ps

module aofc_core_props (
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  input wire logic       sen_n_in,
  input wire logic [7:0] serial_data_out,
  input wire logic       serial_bit_clock_out,
  input wire logic       frame_clock_out,
  input wire logic       two_wire_clock_input_select_out,
  input wire logic       duty_correction_on_out,
  input wire logic       reference_via_common_mode_pin_out
);
  logic [3:0] sel_idle;  // Cycles since select was last low
  logic [5:0] hi_run;    // Consecutive frame-high cycles

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // Helper counters; idle count saturates so long gaps never wrap
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sel_idle <= 4'h0;
      hi_run   <= 6'h00;
    end
    else
    begin
      sel_idle <= !sen_n_in ? 4'h0 : ((sel_idle == 4'hF) ? sel_idle : sel_idle + 4'h1);
      hi_run   <= frame_clock_out ? hi_run + 6'h01 : 6'h00;
    end
  end

  property p_rst_defaults;
    $rose(arst_n_in) |-> !two_wire_clock_input_select_out && !duty_correction_on_out
      && !reference_via_common_mode_pin_out && serial_data_out == 8'h00 && !frame_clock_out;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults)
    else $error("outputs not idle after reset");
  // Config pins move only as a write completes
  property p_two_wire_commit;
    $changed(two_wire_clock_input_select_out) |-> sel_idle < 4'h2;
  endproperty
  a_two_wire_commit: assert property (p_two_wire_commit)
    else $error("clock select moved without a write");
  property p_duty_commit;
    $changed(duty_correction_on_out) |-> sel_idle < 4'h2;
  endproperty
  a_duty_commit: assert property (p_duty_commit)
    else $error("duty correction moved without a write");
  property p_cmr_commit;
    $changed(reference_via_common_mode_pin_out) |-> sel_idle < 4'h2;
  endproperty
  a_cmr_commit: assert property (p_cmr_commit)
    else $error("reference select moved without a write");
  // Bit clock levels last at least two cycles
  property p_bclk_hold;
    $changed(serial_bit_clock_out) && sel_idle > 4'h3 |=> $stable(serial_bit_clock_out);
  endproperty
  a_bclk_hold: assert property (p_bclk_hold)
    else $error("bit clock level lasted one cycle");
  property p_bclk_live;
    $changed(serial_bit_clock_out) && sel_idle > 4'h3 |-> ##[1:4] $changed(serial_bit_clock_out);
  endproperty
  a_bclk_live: assert property (p_bclk_live)
    else $error("bit clock stalled");
  property p_lane_hold;
    $changed(serial_data_out) && sel_idle > 4'h3 |=> $stable(serial_data_out) [*3];
  endproperty
  a_lane_hold: assert property (p_lane_hold)
    else $error("serial bit shorter than four cycles");
  property p_frame_high;
    $fell(frame_clock_out) && hi_run != 6'h00 |-> hi_run == 6'h18;
  endproperty
  a_frame_high: assert property (p_frame_high)
    else $error("frame marker not high for six bits");
  property p_frame_period;
    $rose(frame_clock_out) |-> ##48 $rose(frame_clock_out);
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("word period not twelve bits");
endmodule // aofc_core_props

bind aofc_core aofc_core_props aofc_core_props_inst (
  .mclk_in                           (mclk_in),
  .arst_n_in                         (arst_n_in),
  .sen_n_in                          (sen_n_in),
  .serial_data_out                   (serial_data_out),
  .serial_bit_clock_out              (serial_bit_clock_out),
  .frame_clock_out                   (frame_clock_out),
  .two_wire_clock_input_select_out   (two_wire_clock_input_select_out),
  .duty_correction_on_out            (duty_correction_on_out),
  .reference_via_common_mode_pin_out (reference_via_common_mode_pin_out)
);

/* File: dv/aofc_capture.sv */
// Capture logic on the far side of the serial lanes: rebuilds each word.
// Assumes lanes, bit clock and frame marker share the sample clock.
`timescale 1ns/1ps

module aofc_capture (
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic [7:0]       serial_data_in,
  input  wire logic             bit_clock_in,
  input  wire logic             frame_in,
  output logic      [7:0][11:0] word_out,
  output logic      [15:0]      word_count_out,
  output logic      [7:0]       bclk_pattern_out
);
  logic             frame_prev;  // Frame marker one cycle ago
  logic [5:0]       cnt;         // Cycle position inside the word
  logic [5:0]       pos;         // Position of the current sample
  logic [7:0][11:0] shift_q;     // Bits in arrival order

  assign pos = (frame_in && !frame_prev) ? 6'h00 : cnt;

  // Sample mid-bit; arrival order kept so the bench judges bit order
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      frame_prev       <= 1'b0;
      cnt              <= 6'h00;
      shift_q          <= '0;
      word_out         <= '0;
      word_count_out   <= 16'h0000;
      bclk_pattern_out <= 8'h00;
    end
    else
    begin
      frame_prev <= frame_in;
      cnt        <= pos + 6'h01;
      if (pos < 6'h08)
        bclk_pattern_out[pos[2:0]] <= bit_clock_in;
      if (pos[1:0] == 2'h2 && pos < 6'h30)
        for (int ch = 0; ch < 8; ch++)
          shift_q[ch][pos[5:2]] <= serial_data_in[ch];
      if (pos == 6'h2F)
      begin
        word_out       <= shift_q;
        word_count_out <= word_count_out + 16'h0001;
      end
    end
  end
endmodule // aofc_capture

/* File: dv/test_adc_output_format_config.sv */
// Self-checking bench for the output bank: writes registers, feeds samples.
// Assumes aofc_core, aofc_capture and the bound checker are compiled first.
`timescale 1ns/1ps

module test_adc_output_format_config;
  logic             mclk_in         = 1'b0;
  logic             arst_n_in       = 1'b0;
  logic             sen_n_in        = 1'b1;
  logic             sclk_in         = 1'b0;
  logic             sdata_in        = 1'b0;
  logic             sample_valid_in = 1'b0;
  logic [7:0][11:0] adc_code_in     = '0;
  logic [7:0]       serial_data_out;
  logic             serial_bit_clock_out;
  logic             frame_clock_out;
  logic             two_wire;
  logic             duty;
  logic             cmr;
  logic [7:0][11:0] cap_word;
  logic [7:0][11:0] seen;
  logic [15:0]      cap_count;
  logic [7:0]       bclk_pat;
  int               n_mismatch      = 0;
  int               n_checks        = 0;
  int               cycles          = 0;

  always #5 mclk_in = ~mclk_in;
  aofc_core aofc_core_inst (
    .mclk_in                           (mclk_in),
    .arst_n_in                         (arst_n_in),
    .ce_in                             (1'b1),
    .sen_n_in                          (sen_n_in),
    .sclk_in                           (sclk_in),
    .sdata_in                          (sdata_in),
    .adc_code_in                       (adc_code_in),
    .sample_valid_in                   (sample_valid_in),
    .serial_data_out                   (serial_data_out),
    .serial_bit_clock_out              (serial_bit_clock_out),
    .frame_clock_out                   (frame_clock_out),
    .two_wire_clock_input_select_out   (two_wire),
    .duty_correction_on_out            (duty),
    .reference_via_common_mode_pin_out (cmr)
  );

  aofc_capture aofc_capture_inst (
    .mclk_in          (mclk_in),
    .arst_n_in        (arst_n_in),
    .serial_data_in   (serial_data_out),
    .bit_clock_in     (serial_bit_clock_out),
    .frame_in         (frame_clock_out),
    .word_out         (cap_word),
    .word_count_out   (cap_count),
    .bclk_pattern_out (bclk_pat)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Whole 24-bit frame per write, unused bits zero; link clock idles low
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    logic [23:0] f;
    f = {addr, data};
    sen_n_in <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdata_in <= f[i];
      cyc(4);
      sclk_in <= 1'b1;
      cyc(4);
      sclk_in <= 1'b0;
    end
    cyc(8);
    sen_n_in <= 1'b1;
    cyc(8);
  endtask

  // Bounded wait for whole captured words
  task automatic wait_words(input int n);
    logic [15:0] c0;
    c0 = cap_count;
    for (int k = 0; k < 60 * n && cap_count != c0 + 16'(n); k++)
      cyc(1);
    check(12'(cap_count - c0), 12'(n));
  endtask
  // Three words, so the last surely holds the new sample
  task automatic sample(input logic [11:0] code);
    adc_code_in     <= {8{code}};
    sample_valid_in <= 1'b1;
    cyc(1);
    sample_valid_in <= 1'b0;
    wait_words(3);
    seen = cap_word;
  endtask

  function automatic logic [11:0] order(input logic [11:0] v, input logic msb);
    logic [11:0] r;
    for (int i = 0; i < 12; i++)
      r[i] = msb ? v[11 - i] : v[i];
    return r;
  endfunction

  task automatic lanes(input logic [11:0] e0, input logic [11:0] er);
    for (int ch = 0; ch < 8; ch++)
      check(seen[ch], (ch == 0) ? e0 : er);
  endtask

  task automatic t_defaults;
    check(12'(two_wire), 12'h000);
    check(12'(duty), 12'h000);
    check(12'(cmr), 12'h000);
    sample(12'h123);
    lanes(12'h123, 12'h123);
    check(12'(bclk_pat), 12'h0C3);
  endtask

  task automatic t_clk_ref;
    logic [15:0] sel [3];
    logic [7:0]  pat [4];
    sel = '{16'h0001, 16'h0004, 16'h0008};
    pat = '{8'hC3, 8'h0F, 8'h3C, 8'hF0};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h42, 16'h8000 | sel[i]);
      check(12'({cmr, duty, two_wire}), 12'({sel[i][3], sel[i][2], sel[i][0]}));
    end
    wr(8'h00, 16'h0001);
    check(12'(cmr), 12'h000);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h42, 16'h8000 | 16'(p << 5));
      wait_words(2);
      check(12'(bclk_pat), 12'(pat[p]));
    end
  endtask

  task automatic t_format;
    wr(8'h46, 16'h8204);
    sample(12'h9A5);
    lanes(12'h1A5, 12'h1A5);
    wr(8'h46, 16'h8208);
    sample(12'h9A5);
    lanes(order(12'h9A5, 1'b1), order(12'h9A5, 1'b1));
    wr(8'h46, 16'h8210);
    wait_words(2);
    check(12'(bclk_pat), 12'h0CC);
    wr(8'h46, 16'hA210);
    wait_words(2);
    check(12'(bclk_pat), 12'h033);
    wr(8'h46, 16'h8200);
  endtask

  task automatic t_patterns;
    wr(8'h45, 16'h0001);
    sample(12'h0F0);
    lanes(12'h555, 12'h555);
    wr(8'h45, 16'h0002);
    sample(12'h0F0);
    lanes(12'hFC0, 12'hFC0);
    wr(8'h45, 16'h0000);
    sample(12'h0F0);
    lanes(12'h0F0, 12'h0F0);
  endtask

  // Channel 0 only; the other lanes must stay unchanged
  task automatic t_gain_pol;
    wr(8'h2A, 16'h000C);
    sample(12'h900);
    lanes(12'hBFC, 12'h900);
    wr(8'h2A, 16'h0000);
    wr(8'h24, 16'h0001);
    sample(12'h900);
    lanes(12'h6FF, 12'h900);
    wr(8'h24, 16'h0000);
  endtask

  task automatic t_noise;
    logic l0;
    wr(8'h14, 16'h00FF);
    sample(12'h800);
    l0 = seen[0][0];
    sample(12'h800);
    check(12'(seen[0][0] ^ l0), 12'h001);
    wr(8'h14, 16'h0000);
  endtask

  // Hang guard, well above the sequence length
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end

  // Main sequence
  initial
  begin
    cyc(8);
    arst_n_in <= 1'b1;
    cyc(2);
    t_defaults;
    t_clk_ref;
    t_format;
    t_patterns;
    t_gain_pol;
    t_noise;
    end_of_test;
  end
endmodule // test_adc_output_format_config
